/* File: core/tpa_regs.svh */
// Register offsets, field positions, reset values and timing counts of the phase correct timer.
`ifndef TPA_REGS_SVH
`define TPA_REGS_SVH
`define TPA_ADDR_CTRL_A      4'h0
`define TPA_ADDR_CTRL_B      4'h1
`define TPA_ADDR_COUNT       4'h2
`define TPA_ADDR_CMP_A       4'h3
`define TPA_ADDR_CMP_B       4'h4
`define TPA_ADDR_STATUS      4'h5
`define TPA_ADDR_FLAGS       4'h6
`define TPA_ADDR_IRQ_EN      4'h7
`define TPA_RST_BYTE         8'h00
`define TPA_TOP_FIXED        8'hFF
`define TPA_BOTTOM           8'h00
`define TPA_ONE              8'h01
`define TPA_MODE_PC_FIXED    3'h1
`define TPA_MODE_PC_VAR      3'h5
`define TPA_COM_NONINV       2'h2
`define TPA_COM_INV          2'h3
`define TPA_BIT_ASYNC        3
`define TPA_BIT_OVF          0
`define TPA_BIT_CMPA         1
`define TPA_BIT_CMPB         2
`define TPA_BIT_CNT_UB       4
`define TPA_BIT_CMPA_UB      3
`define TPA_BIT_CMPB_UB      2
`define TPA_BIT_CTLA_UB      1
`define TPA_BIT_CTLB_UB      0
`define TPA_PRE_1            3'h1
`define TPA_PRE_8            3'h2
`define TPA_PRE_32           3'h3
`define TPA_PRE_64           3'h4
`define TPA_PRE_128          3'h5
`define TPA_PRE_256          3'h6
`define TPA_PRE_1024         3'h7
`define TPA_DIV_1            10'h000
`define TPA_DIV_8            10'h007
`define TPA_DIV_32           10'h01F
`define TPA_DIV_64           10'h03F
`define TPA_DIV_128          10'h07F
`define TPA_DIV_256          10'h0FF
`define TPA_DIV_1024         10'h3FF
`define TPA_PRE_ZERO         10'h000
`define TPA_ASYNC_EDGES      2
`define TPA_FLAG_SYNC_CYCLES 3
`endif

/* File: core/tpa_pkg.sv */
// Types shared by the phase correct timer.
package tpa_pkg;
   // One transfer held between the processor and timer domains.
   typedef struct packed {
      logic [7:0] data;
      logic       busy;
   } tpa_hold_type;
   // Count direction of the dual-slope counter.
   typedef enum logic [0:0] {
      TPA_UP   = 1'b0,
      TPA_DOWN = 1'b1
   } tpa_dir_type;
endpackage : tpa_pkg

/* File: core/tpa_timer.sv */
// Phase correct PWM timer with synchronous or asynchronous tick and holding stages on the control, count and compare registers.
`timescale 1ns/1ps
`include "tpa_regs.svh"
module tpa_timer #(
   parameter int CLK_HZ = 40000000
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Register port.
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Oscillator pin and sleep status.
   input  wire logic       async_clock_pin,
   input  wire logic       sleep_active,
   output logic            wake_request,
   // Waveform outputs and interrupt flags.
   output logic            compare_output_pin_a,
   output logic            compare_output_pin_b,
   output logic            overflow_flag,
   output logic            compare_match_flag_a
);
   initial
   begin
      if (CLK_HZ < 1) $error("CLK_HZ must be positive");
   end

   // Pin synchroniser: three stages, change counted when stages two and three agree.
   logic [2:0] pin_sync_reg;
   logic       pin_level_reg;
   logic       pin_prev_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_sync_reg  <= 3'h0;
         pin_level_reg <= 1'b0;
         pin_prev_reg  <= 1'b0;
      end
      else
      begin
         pin_sync_reg <= {pin_sync_reg[1:0], async_clock_pin};
         if (pin_sync_reg[1] == pin_sync_reg[2])
         begin
            pin_level_reg <= pin_sync_reg[2];
         end
         pin_prev_reg <= pin_level_reg;
      end
   end
   // One-cycle pulse per rising edge of the oscillator pin.
   logic async_edge;
   assign async_edge = pin_level_reg & ~pin_prev_reg;

   // Live control values (timer side).
   logic [7:0] ctrl_a_reg;   // Compare modes [7:4], wave mode low bits [1:0].
   logic [7:0] ctrl_b_reg;   // Wave mode high bit [3], prescale [2:0].
   logic [7:0] count_reg;
   logic [7:0] cmp_a_reg;
   logic [7:0] cmp_b_reg;
   logic       async_sel_reg;  // Async_clock_select.
   logic [2:0] irq_en_reg;     // Overflow_irq_enable and compare_irq_enable bits.

   // Holding stages, one per control, count and compare register, each with its own edge count.
   tpa_pkg::tpa_hold_type hold_reg [5];
   logic [1:0]            edge_cnt_reg [5];
   logic [4:0]            load_now;
   logic [4:0]            wr_hit;
   assign wr_hit[0] = reg_wr && reg_addr == `TPA_ADDR_CTRL_A;
   assign wr_hit[1] = reg_wr && reg_addr == `TPA_ADDR_CTRL_B;
   assign wr_hit[2] = reg_wr && reg_addr == `TPA_ADDR_COUNT;
   assign wr_hit[3] = reg_wr && reg_addr == `TPA_ADDR_CMP_A;
   assign wr_hit[4] = reg_wr && reg_addr == `TPA_ADDR_CMP_B;

   // In async mode a write waits two oscillator edges before reaching its destination.
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_hold
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               hold_reg[gi]     <= '{data: `TPA_RST_BYTE, busy: 1'b0};
               edge_cnt_reg[gi] <= 2'h0;
            end
            else if (wr_hit[gi] && async_sel_reg)
            begin
               hold_reg[gi]     <= '{data: reg_wdata, busy: 1'b1};
               edge_cnt_reg[gi] <= 2'h0;
            end
            else if (hold_reg[gi].busy && async_edge)
            begin
               if (edge_cnt_reg[gi] == 2'(`TPA_ASYNC_EDGES - 1))
               begin
                  hold_reg[gi].busy <= 1'b0;
               end
               edge_cnt_reg[gi] <= edge_cnt_reg[gi] + 2'h1;
            end
         end
         // Latch strobe: sync writes land at once, async ones on the second edge.
         assign load_now[gi] = (wr_hit[gi] && !async_sel_reg) ||
                               (hold_reg[gi].busy && async_edge &&
                                edge_cnt_reg[gi] == 2'(`TPA_ASYNC_EDGES - 1));
      end
   endgenerate

   // Values that land in the destination this cycle.
   logic [7:0] land [5];
   always_comb
   begin
      for (int i = 0; i < 5; i++)
      begin
         land[i] = async_sel_reg ? hold_reg[i].data : reg_wdata;
      end
   end

   // Mode decode.
   logic [2:0] wave_mode_sel;
   logic [1:0] compare_output_mode_a;
   logic [1:0] compare_output_mode_b;
   logic       pc_mode;
   logic [7:0] top_value;
   assign wave_mode_sel         = {ctrl_b_reg[3], ctrl_a_reg[1:0]};
   assign compare_output_mode_a = ctrl_a_reg[7:6];
   assign compare_output_mode_b = ctrl_a_reg[5:4];
   assign pc_mode   = wave_mode_sel == `TPA_MODE_PC_FIXED || wave_mode_sel == `TPA_MODE_PC_VAR;
   assign top_value = wave_mode_sel == `TPA_MODE_PC_VAR ? cmp_a_reg : `TPA_TOP_FIXED;

   // Prescaler: terminal count chosen by prescale select; zero stops the timer.
   logic [9:0] pre_cnt_reg;
   logic [9:0] pre_limit;
   logic       src_tick;
   logic       timer_tick;
   assign src_tick = async_sel_reg ? async_edge : 1'b1;
   always_comb
   begin
      case (ctrl_b_reg[2:0])
         `TPA_PRE_1:    pre_limit = `TPA_DIV_1;
         `TPA_PRE_8:    pre_limit = `TPA_DIV_8;
         `TPA_PRE_32:   pre_limit = `TPA_DIV_32;
         `TPA_PRE_64:   pre_limit = `TPA_DIV_64;
         `TPA_PRE_128:  pre_limit = `TPA_DIV_128;
         `TPA_PRE_256:  pre_limit = `TPA_DIV_256;
         `TPA_PRE_1024: pre_limit = `TPA_DIV_1024;
         default:       pre_limit = `TPA_PRE_ZERO;
      endcase
   end
   assign timer_tick = src_tick && ctrl_b_reg[2:0] != 3'h0 && pre_cnt_reg == pre_limit;
   // Prescale counter.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pre_cnt_reg <= `TPA_PRE_ZERO;
      end
      else if (src_tick && ctrl_b_reg[2:0] != 3'h0)
      begin
         pre_cnt_reg <= pre_cnt_reg == pre_limit ? `TPA_PRE_ZERO : pre_cnt_reg + 10'h001;
      end
   end

   // Dual-slope counter: at the fixed top, 255 up plus 255 down ticks gives 510 per period.
   tpa_pkg::tpa_dir_type dir_reg;
   logic                 match_block;
   assign match_block = hold_reg[2].busy | hold_reg[3].busy | hold_reg[4].busy;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg <= `TPA_RST_BYTE;
         dir_reg   <= tpa_pkg::TPA_UP;
      end
      else if (load_now[2])
      begin
         count_reg <= land[2];
      end
      else if (timer_tick)
      begin
         if (!pc_mode)
         begin
            count_reg <= count_reg + `TPA_ONE;
         end
         else if (dir_reg == tpa_pkg::TPA_UP)
         begin
            // Top is shown for one tick, then the direction turns.
            if (count_reg >= top_value)
            begin
               dir_reg   <= tpa_pkg::TPA_DOWN;
               count_reg <= count_reg - `TPA_ONE;
            end
            else
            begin
               count_reg <= count_reg + `TPA_ONE;
            end
         end
         else if (count_reg == `TPA_BOTTOM)
         begin
            dir_reg   <= tpa_pkg::TPA_UP;
            count_reg <= count_reg + `TPA_ONE;
         end
         else
         begin
            count_reg <= count_reg - `TPA_ONE;
         end
      end
   end

   // Compare and control destinations.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_a_reg <= `TPA_RST_BYTE;
         ctrl_b_reg <= `TPA_RST_BYTE;
         cmp_a_reg  <= `TPA_RST_BYTE;
         cmp_b_reg  <= `TPA_RST_BYTE;
      end
      else
      begin
         if (load_now[0]) ctrl_a_reg <= land[0];
         if (load_now[1]) ctrl_b_reg <= land[1];
         if (load_now[3]) cmp_a_reg  <= land[3];
         if (load_now[4]) cmp_b_reg  <= land[4];
      end
   end

   // Waveform per channel: matches act on the tick; at bottom the output is forced to the
   // down-match result so that a missed or skipped match still keeps the period symmetric.
   logic [7:0] cmp_vec [2];
   logic [1:0] com_vec [2];
   logic [1:0] wave_reg;
   logic [1:0] match_hit;
   assign cmp_vec[0] = cmp_a_reg;
   assign cmp_vec[1] = cmp_b_reg;
   assign com_vec[0] = compare_output_mode_a;
   assign com_vec[1] = compare_output_mode_b;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_wave
         logic inv;
         assign inv = com_vec[gi] == `TPA_COM_INV;
         assign match_hit[gi] = timer_tick && !match_block && count_reg == cmp_vec[gi];
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               wave_reg[gi] <= 1'b0;
            end
            else if (timer_tick && pc_mode && com_vec[gi][1])
            begin
               if (count_reg == `TPA_BOTTOM && dir_reg == tpa_pkg::TPA_DOWN)
               begin
                  // Zero compare never rises; otherwise up-counting side is high.
                  wave_reg[gi] <= (cmp_vec[gi] != `TPA_BOTTOM) ^ inv;
               end
               else if (match_hit[gi] && cmp_vec[gi] != `TPA_TOP_FIXED)
               begin
                  wave_reg[gi] <= (dir_reg == tpa_pkg::TPA_DOWN) ^ inv;
               end
               else if (match_hit[gi] && cmp_vec[gi] == `TPA_BOTTOM)
               begin
                  wave_reg[gi] <= inv;
               end
            end
         end
      end
   endgenerate
   assign compare_output_pin_a = wave_reg[0];
   assign compare_output_pin_b = wave_reg[1];

   // Raw events in the timer domain; flags reach software after four clock cycles.
   logic [2:0] event_now;
   logic [2:0] ev_dly_reg [`TPA_FLAG_SYNC_CYCLES];
   logic [2:0] flag_reg;
   logic [2:0] flag_clr;
   assign event_now = {match_hit[1], match_hit[0],
                       timer_tick && pc_mode && count_reg == `TPA_BOTTOM};
   assign flag_clr  = (reg_wr && reg_addr == `TPA_ADDR_FLAGS) ? reg_wdata[2:0] : 3'h0;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < `TPA_FLAG_SYNC_CYCLES; i++) ev_dly_reg[i] <= 3'h0;
         flag_reg <= 3'h0;
      end
      else
      begin
         ev_dly_reg[0] <= event_now;
         for (int i = 1; i < `TPA_FLAG_SYNC_CYCLES; i++) ev_dly_reg[i] <= ev_dly_reg[i-1];
         // A new event wins over a write-one-to-clear in the same cycle.
         flag_reg <= (flag_reg & ~flag_clr) | ev_dly_reg[`TPA_FLAG_SYNC_CYCLES-1];
      end
   end
   assign overflow_flag        = flag_reg[`TPA_BIT_OVF];
   assign compare_match_flag_a = flag_reg[`TPA_BIT_CMPA];

   // Wake request: pending flag seen during sleep raises wake on the next timer tick.
   logic wake_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wake_reg <= 1'b0;
      end
      else if (!sleep_active)
      begin
         wake_reg <= 1'b0;
      end
      else if (timer_tick && |(flag_reg & irq_en_reg))
      begin
         wake_reg <= 1'b1;
      end
   end
   assign wake_request = wake_reg;

   // Counter shadow: refreshed on every oscillator edge in async mode, every cycle otherwise;
   // held while asleep so reads after wake show the old value until the next edge.
   logic [7:0] shadow_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shadow_reg <= `TPA_RST_BYTE;
      end
      else if (!sleep_active && (!async_sel_reg || async_edge))
      begin
         shadow_reg <= count_reg;
      end
   end

   // Clock select and enables are processor-side bits.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         async_sel_reg <= 1'b0;
         irq_en_reg    <= 3'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == `TPA_ADDR_STATUS) async_sel_reg <= reg_wdata[`TPA_BIT_ASYNC];
         if (reg_wr && reg_addr == `TPA_ADDR_IRQ_EN) irq_en_reg    <= reg_wdata[2:0];
      end
   end

   // Read port: data appear the cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= `TPA_RST_BYTE;
      end
      else if (reg_rd)
      begin
         if (reg_addr == `TPA_ADDR_CTRL_A)      reg_rdata <= ctrl_a_reg;
         else if (reg_addr == `TPA_ADDR_CTRL_B) reg_rdata <= ctrl_b_reg;
         else if (reg_addr == `TPA_ADDR_COUNT)  reg_rdata <= shadow_reg;
         else if (reg_addr == `TPA_ADDR_CMP_A)  reg_rdata <= cmp_a_reg;
         else if (reg_addr == `TPA_ADDR_CMP_B)  reg_rdata <= cmp_b_reg;
         else if (reg_addr == `TPA_ADDR_STATUS)
            reg_rdata <= {4'h0, async_sel_reg, 3'h0} |
                         {3'h0, hold_reg[2].busy, hold_reg[3].busy, hold_reg[4].busy,
                          hold_reg[0].busy, hold_reg[1].busy};
         else if (reg_addr == `TPA_ADDR_FLAGS)  reg_rdata <= {5'h00, flag_reg};
         else if (reg_addr == `TPA_ADDR_IRQ_EN) reg_rdata <= {5'h00, irq_en_reg};
         else                                   reg_rdata <= `TPA_RST_BYTE;
      end
   end
endmodule : tpa_timer

/* File: testbench/tpa_osc_model.sv */
// Partner model of the external low-frequency clock on the oscillator pin.
`timescale 1ns/1ps
module tpa_osc_model #(
   parameter int HALF_NS = 130 // Half period; 130 ns is over four clk periods.
) (
   // Control.
   input  wire logic run,
   // Oscillator pin.
   output logic      async_clock_pin
);
   // The oscillator keeps toggling whether or not the core sleeps.
   // The half period is off the clk grid, so phases stay unrelated to the core clock.
   initial async_clock_pin = 1'b0;
   always
   begin
      #(HALF_NS);
      async_clock_pin = run ? ~async_clock_pin : 1'b0;
   end
endmodule : tpa_osc_model

/* File: testbench/tpa_timer_checker.sv */
// Port-level assertions for the phase correct timer.
`timescale 1ns/1ps
`include "tpa_regs.svh"
module tpa_timer_checker (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       arst_n,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Oscillator and sleep.
   input wire logic       async_clock_pin,
   input wire logic       sleep_active,
   input wire logic       wake_request,
   // Outputs.
   input wire logic       compare_output_pin_a,
   input wire logic       compare_output_pin_b,
   input wire logic       overflow_flag,
   input wire logic       compare_match_flag_a
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic async_q; // Mirror of the async select bit, taken from software writes.
   // Track the clock source so that sync and async write rules are told apart.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         async_q <= 1'b0;
      else if (reg_wr && reg_addr == `TPA_ADDR_STATUS)
         async_q <= reg_wdata[`TPA_BIT_ASYNC];
   end
   sequence s_sync_cmp_wr;
      reg_wr && reg_addr == `TPA_ADDR_CMP_A && !async_q;
   endsequence
   sequence s_cmp_rd;
      reg_rd && reg_addr == `TPA_ADDR_CMP_A;
   endsequence
   sequence s_async_cnt_wr;
      reg_wr && reg_addr == `TPA_ADDR_COUNT && async_q;
   endsequence
   sequence s_status_rd;
      reg_rd && reg_addr == `TPA_ADDR_STATUS;
   endsequence
   a_sync_write_lands: assert property (s_sync_cmp_wr ##2 s_cmp_rd |=> reg_rdata == $past(reg_wdata, 3))
      else $error("sync compare write not read back");
   a_async_busy_set: assert property (s_async_cnt_wr ##2 s_status_rd |=> reg_rdata[`TPA_BIT_CNT_UB])
      else $error("count busy bit not set after async write");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ovf_flag_sticky: assert property (overflow_flag && !(reg_wr && reg_addr == `TPA_ADDR_FLAGS
      && reg_wdata[`TPA_BIT_OVF]) |=> overflow_flag)
      else $error("overflow flag dropped without clear");
   a_cmpa_flag_sticky: assert property (compare_match_flag_a && !(reg_wr && reg_addr == `TPA_ADDR_FLAGS
      && reg_wdata[`TPA_BIT_CMPA]) |=> compare_match_flag_a)
      else $error("compare flag dropped without clear");
   a_wake_drops: assert property (!sleep_active |=> !wake_request)
      else $error("wake request held while awake");
   a_wake_in_sleep: assert property ($rose(wake_request) |-> $past(sleep_active))
      else $error("wake request raised outside sleep");
   c_wake: cover property ($rose(wake_request));
endmodule : tpa_timer_checker
bind tpa_timer tpa_timer_checker chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .async_clock_pin(async_clock_pin),
   .sleep_active(sleep_active), .wake_request(wake_request), .compare_output_pin_a(compare_output_pin_a),
   .compare_output_pin_b(compare_output_pin_b), .overflow_flag(overflow_flag),
   .compare_match_flag_a(compare_match_flag_a));

/* File: testbench/tb_tpa_timer.sv */
// Self-checking testbench of the phase correct timer.
`timescale 1ns/1ps
`include "tpa_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_tpa_timer;
   logic       clk;          // Core clock, 25 ns.
   logic       arst_n;       // Active low reset.
   logic [3:0] reg_addr;     // Register index.
   logic [7:0] reg_wdata;    // Write data.
   logic       reg_wr;       // Write strobe.
   logic       reg_rd;       // Read strobe.
   logic [7:0] reg_rdata;    // Read data.
   logic       osc_pin;      // Oscillator pin from the partner.
   logic       sleep_active; // Core sleep level.
   logic       wake_request; // Wake request from the timer.
   logic       pin_a;        // Waveform output A.
   logic       pin_b;        // Waveform output B.
   logic       ovf;          // Overflow flag.
   logic       cmpa;         // Compare A flag.
   logic [7:0] d;            // Last read value.
   int         err_total;    // Mismatches.
   int         comparisons;  // Comparisons made.
   int         hi;           // Measured high time.
   int         per;          // Measured period.
   tpa_osc_model osc (.run(1'b1), .async_clock_pin(osc_pin));
   tpa_timer dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .async_clock_pin(osc_pin), .sleep_active(sleep_active),
      .wake_request(wake_request), .compare_output_pin_a(pin_a), .compare_output_pin_b(pin_b),
      .overflow_flag(ovf), .compare_match_flag_a(cmpa));
   // Free-running core clock.
   always #12.5 clk = ~clk;
   // One-cycle write, then an idle cycle so strobes never double up.
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   // One-cycle read; data is taken mid-cycle when it has settled.
   task automatic rd(input logic [3:0] a);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
   endtask : rd
   // Poll busy bits until every holding register except compare A (bit 3, shared with async select) has landed.
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         rd(`TPA_ADDR_STATUS);
         n++;
      end while ((d & 8'h17) != 8'h00 && n < 100);
      `CHK(d & 8'h17, 8'h00)
      repeat (40) @(posedge clk);
   endtask : wait_idle
   function automatic logic pin_of(input logic s);
      return s ? pin_b : pin_a;
   endfunction : pin_of
   // Measure one full cycle of a waveform output from a rising edge.
   task automatic meas(input logic s);
      int n;
      n = 0;
      hi = 0;
      per = 0;
      // The pin is looked at on the falling edge, where the launching edge has settled.
      while (pin_of(s) !== 1'b0 && n < 20000) begin @(negedge clk); n++; end
      while (pin_of(s) !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
      while (pin_of(s) === 1'b1 && n < 20000) begin @(negedge clk); n++; hi++; per++; end
      while (pin_of(s) === 1'b0 && n < 20000) begin @(negedge clk); n++; per++; end
   endtask : meas
   // Output A must hold one level for more than two full periods.
   task automatic steady(input logic v);
      int bad;
      bad = 0;
      repeat (600) @(posedge clk);
      repeat (1100)
      begin
         @(negedge clk);
         if (pin_a !== v) bad++;
      end
      `CHK(bad, 0)
   endtask : steady
   task automatic final_report();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // Cuts a hang short well past the expected run length.
   initial
   begin
      #1_500_000;
      err_total++;
      final_report();
   end
   initial
   begin
      clk = 1'b0; arst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
      reg_wr = 1'b0; reg_rd = 1'b0; sleep_active = 1'b0;
      err_total = 0; comparisons = 0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // Sync writes land at once; unmapped places read zero and ignore writes.
      wr(`TPA_ADDR_CMP_B, 8'h5C); rd(`TPA_ADDR_CMP_B); `CHK(d, 8'h5C)
      for (int a = 8; a < 16; a++)
      begin
         wr(a[3:0], 8'hFF); rd(a[3:0]); `CHK(d, 8'h00)
      end
      // Fixed top, prescale 1, non-inverting then inverting on channel A.
      wr(`TPA_ADDR_CMP_A, 8'h40); rd(`TPA_ADDR_CMP_A); `CHK(d, 8'h40)
      wr(`TPA_ADDR_CTRL_A, 8'hA1); wr(`TPA_ADDR_CTRL_B, 8'h01);
      repeat (1100) @(posedge clk);
      meas(1'b0); `CHK(hi, 2 * 8'h40)
      `CHK(per, 2 * 255)
      rd(`TPA_ADDR_FLAGS); `CHK(d[`TPA_BIT_OVF], 1'b1)
      wr(`TPA_ADDR_CTRL_A, 8'hE1); repeat (1100) @(posedge clk);
      meas(1'b0); `CHK(hi, 510 - 2 * 8'h40)
      // Extreme compare values, MAX in both polarities, then leaving MAX.
      wr(`TPA_ADDR_CTRL_A, 8'hA1); wr(`TPA_ADDR_CMP_A, 8'h00); steady(1'b0);
      wr(`TPA_ADDR_CMP_A, 8'hFF); steady(1'b1);
      wr(`TPA_ADDR_CTRL_A, 8'hE1); steady(1'b0);
      wr(`TPA_ADDR_CTRL_A, 8'hA1); wr(`TPA_ADDR_CMP_A, 8'h40); repeat (1100) @(posedge clk);
      meas(1'b0); `CHK(hi, 2 * 8'h40)
      // Prescale by 8 stretches the whole period.
      wr(`TPA_ADDR_CTRL_B, 8'h02); repeat (9000) @(posedge clk);
      meas(1'b0); `CHK(hi, 8 * 2 * 8'h40)
      `CHK(per, 8 * 510)
      // Variable top: compare A sets the turning point, channel B modulates.
      wr(`TPA_ADDR_CMP_A, 8'h20); wr(`TPA_ADDR_CMP_B, 8'h10); wr(`TPA_ADDR_CTRL_B, 8'h09);
      repeat (300) @(posedge clk);
      meas(1'b1); `CHK(hi, 2 * 8'h10)
      `CHK(per, 2 * 8'h20)
      `CHK(cmpa, 1'b1)
      `CHK(ovf, 1'b1)
      // Switch to the oscillator in the safe order.
      wr(`TPA_ADDR_IRQ_EN, 8'h00); wr(`TPA_ADDR_STATUS, 8'h08);
      wr(`TPA_ADDR_CTRL_B, 8'h00); wait_idle();
      wr(`TPA_ADDR_COUNT, 8'h5A); rd(`TPA_ADDR_STATUS); `CHK(d[`TPA_BIT_CNT_UB], 1'b1)
      wait_idle(); rd(`TPA_ADDR_COUNT); `CHK(d, 8'h5A)
      wr(`TPA_ADDR_CTRL_A, 8'hA1); wait_idle();
      wr(`TPA_ADDR_CTRL_B, 8'h01); wait_idle();
      wr(`TPA_ADDR_FLAGS, 8'h07); wr(`TPA_ADDR_IRQ_EN, 8'h01);
      // Sleep until the overflow wakes the core.
      sleep_active <= 1'b1;
      for (int n = 0; n < 8000 && wake_request !== 1'b1; n++) @(posedge clk);
      `CHK(wake_request, 1'b1)
      sleep_active <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(wake_request, 1'b0)
      final_report();
   end
endmodule : tb_tpa_timer
